/* verilog/fpmc_pkg.sv */
// Package for the front-panel menu controller: constants, types, map
// Function
// - Session starts on execute; commits only on save-page yes, else discards
// - About 30 s without switch activity abandons edits and restores
// - Committed settings kept in retained storage, reinstated at power-up
// - Power-up display: all segments, version, then frequency and gain
// - Horizontal rocker moves cursor one place left or right
// - Vertical rocker raises or lowers digit under cursor when editing
// - Vertical rocker flips on/off functions in either direction
// - Edited frequency applied only after save confirmed
// - Gain applied live per digit; stored only after yes
// - Yes commits all; no restores frequency and gain, undoing live gain
// - Gain steps are 1 or 10 dB by cursor digit
// - Gain limited to 0 through 50 dB
// - Page order freq, gain, remote, ref, link, address; save after
// - Execute on a page advances to next page; at the top cursor place it jumps to save
// - Alarm raised whenever any synthesizer loop loses lock
// - Mute LED follows mute; remote LED follows remote selection
package fpmc_pkg;
  localparam int unsigned CLK_HZ = 250_000_000;
  localparam int unsigned IDLE_S = 30;
  localparam longint unsigned IDLE_CYC = longint'(IDLE_S) * CLK_HZ;
  localparam int unsigned LAMP_MS = 1000;
  localparam longint unsigned LAMP_CYC = longint'(LAMP_MS) * (CLK_HZ / 1000);
  localparam int unsigned DEB_MS = 10;
  localparam longint unsigned DEB_CYC = longint'(DEB_MS) * (CLK_HZ / 1000);
  // Register byte offsets
  localparam logic [5:0] A_CTRL = 6'h00;
  localparam logic [5:0] A_STATE = 6'h04;
  localparam logic [5:0] A_ISTAT = 6'h08;
  localparam logic [5:0] A_IMASK = 6'h0c;
  localparam logic [5:0] A_NVFRQ = 6'h10;
  localparam logic [5:0] A_NVGN = 6'h14;
  localparam logic [5:0] A_NVOPT = 6'h18;
  localparam logic [5:0] A_VER = 6'h1c;
  // Status bits
  localparam int IB_COMMIT = 0;
  localparam int IB_ABANDON = 1;
  localparam int IB_LOCKLOSS = 2;
  localparam int IB_NVWR = 3;
  localparam int IW = 4;
  localparam logic [10:0] FRQ_MIN = 11'h1f4;
  localparam logic [10:0] FRQ_MAX = 11'h3e8;
  localparam logic [10:0] FRQ_RST = 11'h2ee;
  localparam logic [5:0] GN_MAX = 6'h32;
  localparam logic [5:0] GN_RST = 6'h00;
  localparam logic [4:0] ADR_MAX = 5'h1f;
  localparam logic [31:0] VERSION = 32'h0000_0100; // arbitrary
  typedef enum logic [2:0] {
    PG_IDLE, PG_FRQ, PG_GAIN, PG_REM, PG_REF, PG_LINK, PG_ADDR, PG_SAVE
  } fpmc_page_t;
  typedef enum logic [1:0] {
    PH_LAMP, PH_VER, PH_RUN
  } fpmc_phase_t;
  typedef struct packed {
    logic [10:0] freq;
    logic [5:0] gain;
    logic mute;
    logic remote;
    logic ext_ref;
    logic link485;
    logic [4:0] addr;
  } fpmc_set_t;
  typedef struct packed {
    logic exec;
    logic left;
    logic right;
    logic up;
    logic down;
  } fpmc_sw_t;
endpackage : fpmc_pkg

/* verilog/fpmc_switch_in.sv */
// Switch synchroniser, debouncer and press-pulse generator
module fpmc_switch_in #(
  parameter int unsigned DEB = 32'(fpmc_pkg::DEB_CYC)
) (
  input wire logic mclk, // Clock
  input wire logic rst_n, // Async reset
  input wire logic raw, // Pin, active high
  output logic press // One-cycle press pulse
);
  initial begin
    if (DEB < 1) $error("DEB must be at least one");
  end
  logic s1, s2, s3, level;
  logic [31:0] cnt;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
    end else begin
      s1 <= raw;
      s2 <= s1;
      s3 <= s2;
    end
  end
  wire agree = (s2 == s3);
  wire differ = agree && (s3 != level);
  wire settled = differ && (cnt >= DEB - 1);
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 32'h0;
      level <= 1'b0;
      press <= 1'b0;
    end else begin
      cnt <= (differ && !settled) ? cnt + 32'h1 : 32'h0;
      press <= settled && s3;
      if (settled) begin
        level <= s3;
      end
    end
  end
endmodule : fpmc_switch_in

/* verilog/fpmc_top.sv */
// Front-panel menu controller with Avalon-MM register slave
//
// The implementer's own choices: the Avalon-MM slave port and the placing of the registers.
module fpmc_top #(
  parameter longint unsigned IDLE_CYCLES = fpmc_pkg::IDLE_CYC,
  parameter longint unsigned LAMP_CYCLES = fpmc_pkg::LAMP_CYC,
  parameter longint unsigned DEB_CYCLES = fpmc_pkg::DEB_CYC
) (
  input wire logic mclk, // 250 MHz clock
  input wire logic rst_n, // Async reset, active low
  input wire logic [5:0] avs_address, // Byte address
  input wire logic avs_read, // Read request
  input wire logic avs_write, // Write request
  input wire logic [31:0] avs_writedata, // Write data
  input wire logic [3:0] avs_byteenable, // Byte lanes
  output logic [31:0] avs_readdata, // Read data
  output logic avs_waitrequest, // Stall
  output logic irq, // Level interrupt
  input wire logic [4:0] sw_pins, // exec,left,right,up,down
  input wire logic [1:0] lock_pins, // Synth lock, high = locked
  output logic [10:0] rf_freq, // Applied frequency MHz
  output logic [5:0] rf_gain, // Applied gain dB
  output logic rf_mute, // Applied mute
  output logic rf_ext_ref, // External reference select
  output logic [2:0] lcd_page, // Page shown
  output logic [1:0] lcd_phase, // Power-up display phase
  output logic [3:0] lcd_cursor, // Cursor digit
  output logic [10:0] lcd_freq, // Displayed frequency
  output logic [5:0] lcd_gain, // Displayed gain
  output logic led_alarm, // Alarm LED
  output logic led_mute, // Mute LED
  output logic led_remote // Remote LED
);
  initial begin
    if (IDLE_CYCLES < 1 || LAMP_CYCLES < 1 || DEB_CYCLES < 1) begin
      $error("Cycle counts must be at least one");
    end
  end

  fpmc_pkg::fpmc_sw_t sw_press;
  logic [4:0] press_vec;
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++) begin : g_sw
      fpmc_switch_in #(.DEB(int'(DEB_CYCLES))) u_sw (
        .mclk(mclk),
        .rst_n(rst_n),
        .raw(sw_pins[gi]),
        .press(press_vec[gi])
      );
    end
  endgenerate
  assign sw_press = fpmc_pkg::fpmc_sw_t'(press_vec);
  wire any_press = |press_vec;

  logic [1:0] lk1, lk2, lk3, lock_ok;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      lk1 <= 2'h3;
      lk2 <= 2'h3;
      lk3 <= 2'h3;
      lock_ok <= 2'h3;
    end else begin
      lk1 <= lock_pins;
      lk2 <= lk1;
      lk3 <= lk2;
      // Follow a bit once the second and third stages agree
      lock_ok <= (lock_ok & (lk2 ^ lk3)) | (lk2 & lk3);
    end
  end

  // Retained storage image; written only by commit or software
  fpmc_pkg::fpmc_set_t nv, live, edit;
  fpmc_pkg::fpmc_page_t page;
  fpmc_pkg::fpmc_phase_t phase;
  logic [3:0] cursor;
  logic [63:0] lamp_cnt, idle_cnt;
  logic save_yes;

  function automatic logic [10:0] dstep(input logic [3:0] c);
    case (c)
      4'h0: dstep = 11'h001;
      4'h1: dstep = 11'h00a;
      4'h2: dstep = 11'h064;
      default: dstep = 11'h3e8;
    endcase
  endfunction

  wire in_session = (page != fpmc_pkg::PG_IDLE);
  wire run = (phase == fpmc_pkg::PH_RUN);
  wire on_freq = (page == fpmc_pkg::PG_FRQ);
  wire on_gain = (page == fpmc_pkg::PG_GAIN);
  wire on_save = (page == fpmc_pkg::PG_SAVE);
  wire [3:0] cur_max = on_freq ? 4'h4 : on_gain ? 4'h2 :
                       on_save ? 4'h0 : 4'h1;
  wire timeout = in_session && (idle_cnt >= IDLE_CYCLES - 1);
  // top cursor place of every page except save is the save-jump item
  wire jump = (cursor == cur_max) && !on_save;
  wire [10:0] fstep = dstep(cursor);
  wire [5:0] gstep = (cursor == 4'h0) ? 6'h01 : 6'h0a;
  wire [11:0] f_up = {1'b0, edit.freq} + {1'b0, fstep};
  wire [11:0] f_dn = {1'b0, edit.freq} - {1'b0, fstep};
  wire [10:0] f_new = sw_press.up ?
    ((f_up > {1'b0, fpmc_pkg::FRQ_MAX}) ? fpmc_pkg::FRQ_MAX : f_up[10:0]) :
    ((f_dn[11] || f_dn < {1'b0, fpmc_pkg::FRQ_MIN}) ? fpmc_pkg::FRQ_MIN :
     f_dn[10:0]);
  wire [6:0] g_up = {1'b0, edit.gain} + {1'b0, gstep};
  wire [6:0] g_dn = {1'b0, edit.gain} - {1'b0, gstep};
  wire [5:0] g_new = sw_press.up ?
    ((g_up > {1'b0, fpmc_pkg::GN_MAX}) ? fpmc_pkg::GN_MAX : g_up[5:0]) :
    (g_dn[6] ? 6'h00 : g_dn[5:0]);
  wire vert = sw_press.up || sw_press.down;
  wire commit = on_save && sw_press.exec && save_yes;
  wire discard = (on_save && sw_press.exec && !save_yes) || timeout;

  // Register bus
  logic [3:0] istat, imask;
  logic sw_nv_wr;
  wire bus_wr = avs_write && !avs_waitrequest;
  wire [3:0] set_ev = {sw_nv_wr, 1'b0, 1'b0, 1'b0} |
                      {1'b0, ~&lock_ok & run, discard, commit};
  wire [3:0] clr_ev = (bus_wr && avs_address == fpmc_pkg::A_ISTAT &&
                       avs_byteenable[0]) ? avs_writedata[3:0] : 4'h0;
  logic [31:0] rd_mux;
  always_comb begin
    case (avs_address)
      fpmc_pkg::A_CTRL: rd_mux = {31'h0, save_yes};
      fpmc_pkg::A_STATE: rd_mux = {20'h0, cursor, 2'h0, phase, 1'b0, page};
      fpmc_pkg::A_ISTAT: rd_mux = {28'h0, istat};
      fpmc_pkg::A_IMASK: rd_mux = {28'h0, imask};
      fpmc_pkg::A_NVFRQ: rd_mux = {21'h0, nv.freq};
      fpmc_pkg::A_NVGN: rd_mux = {26'h0, nv.gain};
      fpmc_pkg::A_NVOPT: rd_mux = {23'h0, nv.addr, nv.link485, nv.ext_ref,
                                   nv.remote, nv.mute};
      fpmc_pkg::A_VER: rd_mux = fpmc_pkg::VERSION;
      default: rd_mux = 32'h0;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0;
    end else begin
      avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
      if (avs_read && avs_waitrequest) begin
        avs_readdata <= rd_mux;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      istat <= 4'h0;
      imask <= 4'h0;
      irq <= 1'b0;
    end else begin
      // Set wins over clear
      istat <= (istat & ~clr_ev) | set_ev;
      if (bus_wr && avs_address == fpmc_pkg::A_IMASK && avs_byteenable[0]) begin
        imask <= avs_writedata[3:0];
      end
      irq <= |(istat & imask);
    end
  end

  // retained image, software may preload it (power-return restore)
  wire nv_bus_f = bus_wr && avs_address == fpmc_pkg::A_NVFRQ;
  wire nv_bus_g = bus_wr && avs_address == fpmc_pkg::A_NVGN;
  wire nv_bus_o = bus_wr && avs_address == fpmc_pkg::A_NVOPT;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      nv <= '{fpmc_pkg::FRQ_RST, fpmc_pkg::GN_RST, 1'b0, 1'b0, 1'b0, 1'b0,
              5'h00};
      sw_nv_wr <= 1'b0;
    end else begin
      sw_nv_wr <= commit;
      if (commit) begin
        nv <= edit;
      end else if (!run) begin
        if (nv_bus_f) nv.freq <= avs_writedata[10:0];
        if (nv_bus_g && avs_writedata[5:0] <= fpmc_pkg::GN_MAX) begin
          nv.gain <= avs_writedata[5:0];
        end
        if (nv_bus_o) begin
          {nv.addr, nv.link485, nv.ext_ref, nv.remote, nv.mute} <=
            avs_writedata[8:0];
        end
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      save_yes <= 1'b0;
    end else if (bus_wr && avs_address == fpmc_pkg::A_CTRL) begin
      save_yes <= avs_writedata[0];
    end else if (on_save && vert) begin
      save_yes <= !save_yes;
    end else if (!on_save) begin
      save_yes <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      phase <= fpmc_pkg::PH_LAMP;
      lamp_cnt <= 64'h0;
    end else begin
      case (phase)
        fpmc_pkg::PH_LAMP, fpmc_pkg::PH_VER: begin
          lamp_cnt <= lamp_cnt + 64'h1;
          if (lamp_cnt >= LAMP_CYCLES - 1) begin
            lamp_cnt <= 64'h0;
            phase <= (phase == fpmc_pkg::PH_LAMP) ? fpmc_pkg::PH_VER :
                     fpmc_pkg::PH_RUN;
          end
        end
        fpmc_pkg::PH_RUN: phase <= fpmc_pkg::PH_RUN;
        default: phase <= fpmc_pkg::PH_LAMP;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      idle_cnt <= 64'h0;
    end else if (!in_session || any_press || commit || discard) begin
      idle_cnt <= 64'h0;
    end else begin
      idle_cnt <= idle_cnt + 64'h1;
    end
  end

  // Menu sequencer
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      page <= fpmc_pkg::PG_IDLE;
      cursor <= 4'h0;
      edit <= '0;
    end else if (!run) begin
      edit <= nv;
    end else if (commit || discard) begin
      page <= fpmc_pkg::PG_IDLE;
      cursor <= 4'h0;
      if (discard) edit <= live;
    end else begin
      case (page)
        fpmc_pkg::PG_IDLE: begin
          edit <= live;
          if (sw_press.exec) begin
            page <= fpmc_pkg::PG_FRQ;
          end
        end
        default: begin
          if (sw_press.exec) begin
            cursor <= 4'h0;
            if (jump || page == fpmc_pkg::PG_ADDR) begin
              page <= fpmc_pkg::PG_SAVE;
            end else begin
              page <= fpmc_pkg::fpmc_page_t'(page + 3'h1);
            end
          end else if (sw_press.left && cursor < cur_max) begin
            cursor <= cursor + 4'h1;
          end else if (sw_press.right && cursor != 4'h0) begin
            cursor <= cursor - 4'h1;
          end else if (vert && cursor != cur_max) begin
            case (page)
              fpmc_pkg::PG_FRQ: edit.freq <= f_new;
              fpmc_pkg::PG_GAIN: edit.gain <= g_new;
              fpmc_pkg::PG_REM: edit.remote <= !edit.remote;
              fpmc_pkg::PG_REF: edit.ext_ref <= !edit.ext_ref;
              fpmc_pkg::PG_LINK: edit.link485 <= !edit.link485;
              fpmc_pkg::PG_ADDR: begin
                edit.addr <= sw_press.up ? edit.addr + 5'h01 :
                             edit.addr - 5'h01;
              end
              default: edit.mute <= edit.mute;
            endcase
          end
        end
      endcase
    end
  end

  // Applied settings
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      live <= '{fpmc_pkg::FRQ_RST, fpmc_pkg::GN_RST, 1'b0, 1'b0, 1'b0, 1'b0,
                5'h00};
    end else if (!run) begin
      live <= nv;
    end else if (commit) begin
      live <= edit;
    end else if (discard) begin
      live.gain <= nv.gain;
    end else if (on_gain) begin
      live.gain <= edit.gain;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rf_freq <= fpmc_pkg::FRQ_RST;
      rf_gain <= fpmc_pkg::GN_RST;
      rf_mute <= 1'b1;
      rf_ext_ref <= 1'b0;
      lcd_page <= 3'h0;
      lcd_phase <= 2'h0;
      lcd_cursor <= 4'h0;
      lcd_freq <= 11'h0;
      lcd_gain <= 6'h0;
      led_alarm <= 1'b0;
      led_mute <= 1'b0;
      led_remote <= 1'b0;
    end else begin
      rf_freq <= live.freq;
      rf_gain <= live.gain;
      rf_mute <= live.mute || !run;
      rf_ext_ref <= live.ext_ref;
      lcd_page <= page;
      lcd_phase <= phase;
      lcd_cursor <= cursor;
      lcd_freq <= in_session ? edit.freq : live.freq;
      lcd_gain <= in_session ? edit.gain : live.gain;
      led_alarm <= ~&lock_ok;
      led_mute <= live.mute;
      led_remote <= live.remote;
    end
  end
endmodule : fpmc_top

/* verif/fpmc_props.sv */
// Concurrent checks on the menu controller ports
module fpmc_props #(
  parameter longint unsigned IDLE_CYCLES = 200,
  parameter longint unsigned DEB_CYCLES = 2
) (
  input wire logic mclk, // Clock
  input wire logic rst_n, // Async reset
  input wire logic [4:0] sw_pins, // Switch levels
  input wire logic [1:0] lock_pins, // Synth lock
  input wire logic [10:0] rf_freq, // Applied frequency
  input wire logic [5:0] rf_gain, // Applied gain
  input wire logic rf_mute, // Applied mute
  input wire logic [2:0] lcd_page, // Page shown
  input wire logic [1:0] lcd_phase, // Power-up phase
  input wire logic [5:0] lcd_gain, // Shown gain
  input wire logic led_alarm, // Alarm LED
  input wire logic led_mute // Mute LED
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  logic [31:0] quiet;
  logic [4:0] sw_q;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n)
      sw_q <= 5'h00;
    else
      sw_q <= sw_pins;
  end
  // Cycles in a session with no switch change
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n)
      quiet <= 32'h0;
    else if (lcd_page == 3'h0 || sw_pins != sw_q)
      quiet <= 32'h0;
    else
      quiet <= quiet + 32'h1;
  end
  property p_phase;
    1 |=> lcd_phase != 2'h3 && (lcd_phase == $past(lcd_phase) ||
      lcd_phase == $past(lcd_phase) + 2'h1);
  endproperty
  a_phase: assert property (p_phase) else $error("phase order");
  property p_gain_lim;
    1 |-> rf_gain <= 6'h32 && lcd_gain <= 6'h32;
  endproperty
  a_gain_lim: assert property (p_gain_lim) else $error("gain limit");
  property p_start;
    $past(lcd_page) == 3'h0 && lcd_page != 3'h0 |-> lcd_page == 3'h1;
  endproperty
  a_start: assert property (p_start) else $error("session start");
  property p_order;
    $changed(lcd_page) && $past(lcd_page) inside {[3'h1:3'h5]} |->
      lcd_page == $past(lcd_page) + 3'h1 || lcd_page inside {3'h0, 3'h7};
  endproperty
  a_order: assert property (p_order) else $error("page order");
  property p_freq_hold;
    $changed(rf_freq) && $past(lcd_phase) == 2'h2 |->
      $past(lcd_page) == 3'h7 || $past(lcd_page, 2) == 3'h7;
  endproperty
  a_freq_hold: assert property (p_freq_hold) else $error("freq early");
  property p_alarm;
    (lock_pins != 2'h3) [*6] |-> led_alarm;
  endproperty
  a_alarm: assert property (p_alarm) else $error("alarm missing");
  property p_mute_led;
    (lcd_phase == 2'h2 && $stable(rf_mute)) [*3] |-> led_mute == rf_mute;
  endproperty
  a_mute_led: assert property (p_mute_led) else $error("mute led");
  property p_live_gain;
    (lcd_page == 3'h2 && $stable(lcd_gain)) [*3] |-> rf_gain == lcd_gain;
  endproperty
  a_live_gain: assert property (p_live_gain) else $error("live gain");
  property p_idle;
    1 |-> quiet <= IDLE_CYCLES + DEB_CYCLES + 16;
  endproperty
  a_idle: assert property (p_idle) else $error("no abandon");
endmodule : fpmc_props
bind fpmc_top fpmc_props #(.IDLE_CYCLES(IDLE_CYCLES), .DEB_CYCLES(DEB_CYCLES))
  i_fpmc_props (.mclk(mclk), .rst_n(rst_n), .sw_pins(sw_pins),
  .lock_pins(lock_pins), .rf_freq(rf_freq), .rf_gain(rf_gain),
  .rf_mute(rf_mute), .lcd_page(lcd_page), .lcd_phase(lcd_phase),
  .lcd_gain(lcd_gain), .led_alarm(led_alarm), .led_mute(led_mute));

/* verif/fpmc_operator.sv */
// Operator model pressing the front-panel switches
module fpmc_operator #(
  parameter int HOLD = 10
) (
  input wire logic mclk, // Clock
  output logic [4:0] sw_pins // Switch levels
);
  timeunit 1ns;
  timeprecision 1ps;
  initial sw_pins = 5'h00;
  // Hold past debounce, then release as long
  task automatic press(input int k);
    @(posedge mclk);
    sw_pins <= 5'h01 << k;
    repeat (HOLD) @(posedge mclk);
    sw_pins <= 5'h00;
    repeat (HOLD) @(posedge mclk);
  endtask : press
endmodule : fpmc_operator

/* verif/tb_top.sv */
// Self-checking bench for the front-panel menu controller
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int EX = 4;
  localparam int LF = 3;
  localparam int RT = 2;
  localparam int UP = 1;
  localparam int DN = 0;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [5:0] avs_address = 6'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hf;
  logic [31:0] avs_readdata, rd;
  logic avs_waitrequest, irq, rf_mute, rf_ext_ref;
  logic led_alarm, led_mute, led_remote;
  logic [4:0] sw_pins;
  logic [1:0] lock_pins = 2'h3;
  logic [10:0] rf_freq, lcd_freq, f;
  logic [5:0] rf_gain, lcd_gain, g;
  logic [2:0] lcd_page;
  logic [1:0] lcd_phase;
  logic [3:0] lcd_cursor;
  logic [8:0] o;
  int error_cnt = 0;
  int cmp_count = 0;
  int cyc = 0;
  int n;
  always #2 mclk = ~mclk;
  fpmc_top #(.IDLE_CYCLES(200), .LAMP_CYCLES(8), .DEB_CYCLES(2)) i_fpmc_top (
    .mclk(mclk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .irq(irq), .sw_pins(sw_pins),
    .lock_pins(lock_pins), .rf_freq(rf_freq), .rf_gain(rf_gain),
    .rf_mute(rf_mute), .rf_ext_ref(rf_ext_ref), .lcd_page(lcd_page),
    .lcd_phase(lcd_phase), .lcd_cursor(lcd_cursor), .lcd_freq(lcd_freq),
    .lcd_gain(lcd_gain), .led_alarm(led_alarm), .led_mute(led_mute),
    .led_remote(led_remote));
  fpmc_operator i_fpmc_operator (.mclk(mclk), .sw_pins(sw_pins));
  task automatic summarize();
    if (error_cnt == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : summarize
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Avalon-MM access, held until waitrequest samples low
  task automatic bus(input logic wr, input logic [5:0] a, input int d);
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !wr;
    avs_write <= wr;
    do begin
      @(posedge mclk);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus
  task automatic sw(input int k);
    i_fpmc_operator.press(k);
  endtask : sw
  task automatic cur(input logic [3:0] c);
    repeat (4) if (lcd_cursor !== c) sw(lcd_cursor > c ? RT : LF);
  endtask : cur
  task automatic save(input logic y);
    bus(1'b0, fpmc_pkg::A_CTRL, 0);
    if (rd[0] !== y) sw(UP);
    sw(EX);
  endtask : save
  function automatic logic [5:0] gstep(input logic [5:0] v, input int s);
    return (v + s > 50) ? 6'h32 : v + 6'(s);
  endfunction : gstep
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      summarize();
    end
  end
  initial begin
    void'($urandom(32'h9bfeab0c));
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    o = 9'($urandom_range(511));
    bus(1'b1, fpmc_pkg::A_NVFRQ, 32'h258);
    bus(1'b1, fpmc_pkg::A_NVGN, 32'h14);
    bus(1'b1, fpmc_pkg::A_NVOPT, o);
    bus(1'b1, fpmc_pkg::A_IMASK, 32'h1);
    repeat (20) @(posedge mclk);
    chk(lcd_phase, 2'h2);
    chk(rf_freq, 11'h258);
    chk(rf_gain, 6'h14);
    chk(led_mute, o[0]);
    chk(rf_mute, o[0]);
    chk(led_remote, o[1]);
    chk(rf_ext_ref, o[2]);
    bus(1'b0, fpmc_pkg::A_NVOPT, 0);
    chk(rd, o);
    bus(1'b0, fpmc_pkg::A_VER, 0);
    chk(rd, fpmc_pkg::VERSION);
    bus(1'b0, 6'h24, 32'hffff);
    chk(rd, 0);
    sw(UP);
    chk(lcd_page, 3'h0);
    sw(EX);
    sw(EX);
    chk(lcd_page, 3'h2);
    cur(0);
    sw(UP);
    chk(rf_gain, 6'h15);
    cur(1);
    sw(UP);
    chk(rf_gain, 6'h1f);
    sw(EX);
    chk(lcd_page, 3'h3);
    cur(1);
    sw(EX);
    chk(lcd_page, 3'h7);
    save(1'b0);
    chk(rf_gain, 6'h14);
    chk(irq, 1'b0);
    sw(EX);
    cur(0);
    n = $urandom_range(3, 1);
    repeat (n) sw(UP);
    f = 11'h258 + 11'(n);
    chk(lcd_freq, f);
    chk(rf_freq, 11'h258);
    sw(LF);
    chk(lcd_cursor, 4'h1);
    sw(LF);
    sw(RT);
    chk(lcd_cursor, 4'h1);
    sw(LF);
    sw(UP);
    sw(DN);
    sw(UP);
    f = f + 11'd100;
    chk(lcd_freq, f);
    sw(EX);
    cur(1);
    g = 6'h14;
    repeat (4) begin
      sw(UP);
      g = gstep(g, 10);
    end
    chk(lcd_gain, g);
    sw(EX);
    cur(0);
    sw(DN);
    cur(1);
    sw(EX);
    save(1'b1);
    chk(rf_freq, f);
    chk(rf_gain, g);
    chk(led_remote, !o[1]);
    chk(irq, 1'b1);
    bus(1'b0, fpmc_pkg::A_NVGN, 0);
    chk(rd, g);
    bus(1'b1, fpmc_pkg::A_ISTAT, 32'hf);
    repeat (3) @(posedge mclk);
    chk(irq, 1'b0);
    sw(EX);
    repeat (130) @(posedge mclk);
    sw(UP);
    repeat (150) @(posedge mclk);
    chk(lcd_page, 3'h1);
    repeat (100) @(posedge mclk);
    chk(lcd_page, 3'h0);
    chk(lcd_freq, f);
    bus(1'b0, fpmc_pkg::A_ISTAT, 0);
    chk(rd & 32'h3, 32'h2);
    chk(irq, 1'b0);
    bus(1'b1, fpmc_pkg::A_IMASK, 32'h4);
    lock_pins <= 2'h2;
    repeat (10) @(posedge mclk);
    chk(led_alarm, 1'b1);
    chk(irq, 1'b1);
    lock_pins <= 2'h3;
    repeat (10) @(posedge mclk);
    chk(led_alarm, 1'b0);
    summarize();
  end
endmodule : tb_top
